// file: inc/tcpo_pkg.sv
// Constants and carrier types for the timer compare and PWM output block.
// Assumes a 4-bit word address on a plain strobe register port.
package tcpo_pkg;

	localparam int DATA_W = 16;
	localparam int ADDR_W = 4;

	// Register word addresses
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_IO_AB = 4'h1;
	localparam logic [3:0] ADDR_IO_CD = 4'h2;
	localparam logic [3:0] ADDR_STATUS = 4'h3;
	localparam logic [3:0] ADDR_STAT_CLR = 4'h4;
	localparam logic [3:0] ADDR_IRQ_EN = 4'h5;
	localparam logic [3:0] ADDR_GR_A = 4'h6;
	localparam logic [3:0] ADDR_GR_B = 4'h7;
	localparam logic [3:0] ADDR_GR_C = 4'h8;
	localparam logic [3:0] ADDR_GR_D = 4'h9;
	localparam logic [3:0] ADDR_COUNT = 4'ha;
	localparam logic [3:0] ADDR_PORT_DIR = 4'hb;
	localparam logic [3:0] ADDR_PORT_DATA = 4'hc;

	// Field positions inside the two io control registers and the port registers
	localparam int IO_LO_POS = 0;
	localparam int IO_HI_POS = 4;
	localparam int PORT_BIT_POS = 4;

	// Per-match output selections
	localparam logic [2:0] IO_NONE = 3'h0;
	localparam logic [2:0] IO_OUT0 = 3'h1;
	localparam logic [2:0] IO_OUT1 = 3'h2;
	localparam logic [2:0] IO_TOGGLE = 3'h3;

	// Reset values
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [6:0] IO_RST = 7'h00;
	localparam logic [15:0] GR_RST = 16'hffff;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [3:0] STAT_RST = 4'h0;

	// Timer control register layout
	typedef struct packed {
		logic [4:0] rsvd_hi;
		logic pwm_d;
		logic pwm_c;
		logic pwm_b;
		logic [1:0] rsvd_lo;
		logic pwm_level_d;
		logic pwm_level_c;
		logic pwm_level_b;
		logic initial_level_a;
		logic clear_on_match_a;
		logic run;
	} tcpo_ctrl_s;

	localparam logic [15:0] CTRL_WMASK = 16'h073f;

	// Register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} tcpo_req_s;

endpackage : tcpo_pkg

// file: core/tcpo_top.sv
// Timer compare-match outputs, PWM generation and shared pin D multiplexer.
// Assumes one 40 MHz clock, a synchronous reset and an external pin wire
// resolved from pin_d_o and pin_d_oe_o by the surroundings.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module tcpo_top #(
	parameter int CNT_W = 16
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	output logic irq_o,
	output logic timer_pin_a_o,
	output logic timer_pin_b_o,
	output logic timer_pin_c_o,
	output logic [2:0] timer_pin_oe_o,
	input wire logic pin_d_i,
	output logic pin_d_o,
	output logic pin_d_oe_o,
	output logic timer_in_d_o
);

	// Only a 16-bit count is served by the register port and compares
	if (CNT_W != 16) begin : g_bad_width
		$error("tcpo_top: count width must be 16");
	end

	tcpo_pkg::tcpo_req_s req;
	assign req = '{addr: reg_addr_i, wdata: reg_wdata_i,
		wr: reg_wr_i, rd: reg_rd_i};

	tcpo_pkg::tcpo_ctrl_s ctrl_r;
	logic [6:0] io_ab_r;
	logic [6:0] io_cd_r;
	logic [3:0] status_r;
	logic [3:0] irq_en_r;
	logic [15:0] gr_r [4];
	logic [15:0] count_r;
	logic [15:0] count_nxt;
	logic port_dir_r;
	logic port_data_r;
	logic [3:0] tout_r;
	logic [3:0] tout_nxt;
	logic [15:0] rdata_nxt;
	logic pin_sync1_r;
	logic pin_sync2_r;

	// Write decode
	wire ctrl_wr = req.wr && req.addr == tcpo_pkg::ADDR_CTRL;
	wire io_ab_wr = req.wr && req.addr == tcpo_pkg::ADDR_IO_AB;
	wire io_cd_wr = req.wr && req.addr == tcpo_pkg::ADDR_IO_CD;
	wire clr_wr = req.wr && req.addr == tcpo_pkg::ADDR_STAT_CLR;
	wire en_wr = req.wr && req.addr == tcpo_pkg::ADDR_IRQ_EN;
	wire cnt_wr = req.wr && req.addr == tcpo_pkg::ADDR_COUNT;
	wire dir_wr = req.wr && req.addr == tcpo_pkg::ADDR_PORT_DIR;
	wire data_wr = req.wr && req.addr == tcpo_pkg::ADDR_PORT_DATA;
	wire gr_wr_any = req.wr && req.addr >= tcpo_pkg::ADDR_GR_A &&
		req.addr <= tcpo_pkg::ADDR_GR_D;
	wire [1:0] gr_idx = 2'(req.addr - tcpo_pkg::ADDR_GR_A);

	// Per-channel selections and modes
	wire [2:0] io_sel [4];
	assign io_sel[0] = io_ab_r[tcpo_pkg::IO_LO_POS +: 3];
	assign io_sel[1] = io_ab_r[tcpo_pkg::IO_HI_POS +: 3];
	assign io_sel[2] = io_cd_r[tcpo_pkg::IO_LO_POS +: 3];
	assign io_sel[3] = io_cd_r[tcpo_pkg::IO_HI_POS +: 3];
	wire [3:0] pwm_on = {ctrl_r.pwm_d, ctrl_r.pwm_c, ctrl_r.pwm_b, 1'b0};
	wire [3:0] level = {ctrl_r.pwm_level_d, ctrl_r.pwm_level_c,
		ctrl_r.pwm_level_b, ctrl_r.initial_level_a};

	// Compare against the running count
	wire [3:0] match;
	wire [3:0] drive;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_ch
			// Every register compares in PWM mode too
			assign match[gi] = ctrl_r.run && count_r == gr_r[gi];
			assign drive[gi] = pwm_on[gi] ||
				(!io_sel[gi][2] && io_sel[gi] != tcpo_pkg::IO_NONE);
			wire same_as_period = gr_r[gi] == gr_r[0];
			logic cmp_val;
			always_comb begin
				case (io_sel[gi])
					tcpo_pkg::IO_OUT0: cmp_val = 1'b0;
					tcpo_pkg::IO_OUT1: cmp_val = 1'b1;
					tcpo_pkg::IO_TOGGLE: cmp_val = !tout_r[gi];
					default: cmp_val = tout_r[gi];
				endcase
			end
			always_comb begin
				if (ctrl_wr) begin
					// Level bits also preset the outputs
					tout_nxt[gi] = reg_wdata_i[2 + gi];
				end else if (pwm_on[gi]) begin
					// Selections are ignored on PWM pins
					if (same_as_period) begin
						tout_nxt[gi] = tout_r[gi];
					end else if (match[0]) begin
						tout_nxt[gi] = level[gi];
					end else if (match[gi]) begin
						tout_nxt[gi] = !level[gi];
					end else begin
						tout_nxt[gi] = tout_r[gi];
					end
				end else if (match[gi]) begin
					tout_nxt[gi] = cmp_val;
				end else begin
					tout_nxt[gi] = tout_r[gi];
				end
			end
		end
	endgenerate

	// Periodic clear on match A; counting resumes from zero
	assign count_nxt = cnt_wr ? reg_wdata_i :
		!ctrl_r.run ? count_r :
		(match[0] && ctrl_r.clear_on_match_a) ? tcpo_pkg::COUNT_RST :
		16'(count_r + 16'h0001);

	// Pin D ownership: timer output or port bit
	wire pin_d_timer = drive[3];
	wire pin_d_out_nxt = pin_d_timer ? tout_nxt[3] : port_data_r;
	wire pin_d_oe_nxt = pin_d_timer || port_dir_r;
	wire port_rd_val = port_dir_r ? port_data_r : pin_sync2_r;

	always_comb begin
		rdata_nxt = 16'h0000;
		case (req.addr)
			tcpo_pkg::ADDR_CTRL: rdata_nxt = ctrl_r;
			tcpo_pkg::ADDR_IO_AB: rdata_nxt = {9'h000, io_ab_r};
			tcpo_pkg::ADDR_IO_CD: rdata_nxt = {9'h000, io_cd_r};
			tcpo_pkg::ADDR_STATUS: rdata_nxt = {12'h000, status_r};
			tcpo_pkg::ADDR_IRQ_EN: rdata_nxt = {12'h000, irq_en_r};
			tcpo_pkg::ADDR_GR_A: rdata_nxt = gr_r[0];
			tcpo_pkg::ADDR_GR_B: rdata_nxt = gr_r[1];
			tcpo_pkg::ADDR_GR_C: rdata_nxt = gr_r[2];
			tcpo_pkg::ADDR_GR_D: rdata_nxt = gr_r[3];
			tcpo_pkg::ADDR_COUNT: rdata_nxt = count_r;
			tcpo_pkg::ADDR_PORT_DIR:
				rdata_nxt[tcpo_pkg::PORT_BIT_POS] = port_dir_r;
			tcpo_pkg::ADDR_PORT_DATA:
				rdata_nxt[tcpo_pkg::PORT_BIT_POS] = port_rd_val;
			default: rdata_nxt = 16'h0000;
		endcase
		if (!req.rd) begin
			rdata_nxt = 16'h0000;
		end
	end

	// Pin input synchroniser
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			pin_sync1_r <= 1'b0;
			pin_sync2_r <= 1'b0;
		end else begin
			pin_sync1_r <= pin_d_i;
			pin_sync2_r <= pin_sync1_r;
		end
	end

	// Software registers
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			ctrl_r <= tcpo_pkg::CTRL_RST;
			io_ab_r <= tcpo_pkg::IO_RST;
			io_cd_r <= tcpo_pkg::IO_RST;
			irq_en_r <= tcpo_pkg::STAT_RST;
			port_dir_r <= 1'b0;
			port_data_r <= 1'b0;
		end else begin
			if (ctrl_wr) ctrl_r <= reg_wdata_i & tcpo_pkg::CTRL_WMASK;
			if (io_ab_wr) io_ab_r <= reg_wdata_i[6:0] & 7'h77;
			if (io_cd_wr) io_cd_r <= reg_wdata_i[6:0] & 7'h77;
			if (en_wr) irq_en_r <= reg_wdata_i[3:0];
			if (dir_wr) port_dir_r <= reg_wdata_i[tcpo_pkg::PORT_BIT_POS];
			if (data_wr) port_data_r <= reg_wdata_i[tcpo_pkg::PORT_BIT_POS];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < 4; i++) begin
				gr_r[i] <= tcpo_pkg::GR_RST;
			end
		end else if (gr_wr_any) begin
			gr_r[gr_idx] <= reg_wdata_i;
		end
	end

	// Counter, flags and outputs; a new match wins over a clear
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			count_r <= tcpo_pkg::COUNT_RST;
			status_r <= tcpo_pkg::STAT_RST;
			tout_r <= 4'h0;
		end else begin
			count_r <= count_nxt;
			status_r <= (status_r & ~(clr_wr ? reg_wdata_i[3:0] : 4'h0))
				| match;
			tout_r <= tout_nxt;
		end
	end

	// Registered outputs
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 16'h0000;
			irq_o <= 1'b0;
			timer_pin_a_o <= 1'b0;
			timer_pin_b_o <= 1'b0;
			timer_pin_c_o <= 1'b0;
			timer_pin_oe_o <= 3'h0;
			pin_d_o <= 1'b0;
			pin_d_oe_o <= 1'b0;
			timer_in_d_o <= 1'b0;
		end else begin
			reg_rdata_o <= rdata_nxt;
			irq_o <= |(status_r & irq_en_r);
			timer_pin_a_o <= tout_nxt[0];
			timer_pin_b_o <= tout_nxt[1];
			timer_pin_c_o <= tout_nxt[2];
			timer_pin_oe_o <= drive[2:0];
			pin_d_o <= pin_d_out_nxt;
			pin_d_oe_o <= pin_d_oe_nxt;
			timer_in_d_o <= pin_sync2_r;
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	count_clear_a: assert property (
		match[0] && ctrl_r.clear_on_match_a && !cnt_wr
		|=> count_r == 16'h0000 ##1 count_r == 16'h0001 || !ctrl_r.run
		|| $past(cnt_wr))
		else $error("count not cleared on match A");

	flag_a_set_a: assert property (
		match[0] |=> status_r[0])
		else $error("match A flag not set");

	irq_gate_a: assert property (
		status_r[0] && irq_en_r[0] |=> irq_o)
		else $error("interrupt missing while enabled");

	irq_quiet_a: assert property (
		(status_r & irq_en_r) == 4'h0 |=> !irq_o)
		else $error("interrupt raised while masked");

	out_high_a: assert property (
		match[1] && !pwm_on[1] && io_sel[1] == tcpo_pkg::IO_OUT1
		&& !ctrl_wr |=> tout_r[1] && timer_pin_b_o)
		else $error("output 1 not driven on match B");

	out_hold_a: assert property (
		match[1] && !pwm_on[1] && io_sel[1] == tcpo_pkg::IO_OUT0
		&& !tout_r[1] && !ctrl_wr |=> !tout_r[1])
		else $error("pin changed although already at level");

	pwm_rise_a: assert property (
		pwm_on[1] && match[0] && level[1] && gr_r[1] != gr_r[0]
		&& !ctrl_wr |=> tout_r[1])
		else $error("PWM B not high at period match");

	pwm_fall_a: assert property (
		pwm_on[1] && match[0] && !level[1] && gr_r[1] != gr_r[0]
		&& !ctrl_wr |=> !tout_r[1])
		else $error("PWM B not low at period match");

	pwm_steady_a: assert property (
		pwm_on[2] && gr_r[2] == gr_r[0] && !ctrl_wr
		|=> $stable(tout_r[2]))
		else $error("PWM C changed with duty equal period");

	pin_d_timer_a: assert property (
		io_sel[3][2:1] == 2'h1 || io_sel[3] == tcpo_pkg::IO_OUT0
		|=> pin_d_oe_o && pin_d_o == tout_r[3])
		else $error("pin D not driven by timer");

	pin_d_port_a: assert property (
		io_sel[3][2] && !pwm_on[3]
		|=> pin_d_oe_o == $past(port_dir_r))
		else $error("pin D not returned to port");

	// Further guards on counting, flags, compare outputs, pin D and read data

	count_step_a: assert property (
		ctrl_r.run && !match[0] && !cnt_wr
		|=> count_r == 16'($past(count_r) + 16'h0001))
		else $error("count did not step while running");

	flag_sticky_a: assert property (
		status_r[1] && !clr_wr |=> status_r[1])
		else $error("match flag lost without a clear");

	flag_clear_a: assert property (
		clr_wr && reg_wdata_i[0] && !match[0] |=> !status_r[0])
		else $error("match A flag not cleared");

	out_low_a: assert property (
		match[0] && io_sel[0] == tcpo_pkg::IO_OUT0 && !ctrl_wr
		|=> !tout_r[0] && !timer_pin_a_o)
		else $error("output 0 not driven on match A");

	out_toggle_a: assert property (
		match[0] && io_sel[0] == tcpo_pkg::IO_TOGGLE && !ctrl_wr
		|=> tout_r[0] != $past(tout_r[0]))
		else $error("output A not toggled on match");

	oe_compare_a: assert property (
		io_sel[0] == tcpo_pkg::IO_OUT1 |=> timer_pin_oe_o[0])
		else $error("pin A not driven for compare output");

	pwm_duty_a: assert property (
		pwm_on[1] && match[1] && !match[0] && gr_r[1] != gr_r[0]
		&& !ctrl_wr |=> tout_r[1] != level[1])
		else $error("PWM B wrong level at duty match");

	pwm_oe_b_a: assert property (
		pwm_on[1] |=> timer_pin_oe_o[1])
		else $error("PWM B pin not driven");

	pwm_oe_d_a: assert property (
		pwm_on[3] |=> pin_d_oe_o)
		else $error("PWM D pin not driven");

	pwm_ignore_a: assert property (
		pwm_on[2] && !match[0] && !match[2] && !ctrl_wr
		|=> $stable(tout_r[2]))
		else $error("PWM C moved by a per-match selection");

	pin_d_gpio_a: assert property (
		io_sel[3] == tcpo_pkg::IO_NONE && !pwm_on[3]
		|=> pin_d_oe_o == $past(port_dir_r)
		&& (!$past(port_dir_r) || pin_d_o == $past(port_data_r)))
		else $error("pin D not acting as port bit");

	timer_in_a: assert property (
		$past(rst_n_i, 1) && $past(rst_n_i, 2) && $past(rst_n_i, 3)
		|-> timer_in_d_o == $past(pin_d_i, 3))
		else $error("timer input D does not follow the pin");

	rdata_idle_a: assert property (
		!reg_rd_i |=> reg_rdata_o == 16'h0000)
		else $error("read data not zero outside a read");

endmodule : tcpo_top

// file: verification/tcpo_pin_load.sv
// Loads on the timer pins: a pulled-up shared pin D and duty counters.
// Assumes registered pin outputs that change after ref_clk_i edges.
`timescale 1ns/1ps
module tcpo_pin_load (
	input wire logic ref_clk_i,
	input wire logic meas_i,
	input wire logic [2:0] pins_i,
	input wire logic pin_d_o_i,
	input wire logic pin_d_oe_i,
	input wire logic ext_en_i,
	input wire logic ext_lvl_i,
	output logic pin_d_lvl_o,
	output logic [2:0][7:0] high_cnt_o
);
	// Pull-up holds the wire high when nobody drives it
	assign pin_d_lvl_o = pin_d_oe_i ? pin_d_o_i : (ext_en_i ? ext_lvl_i : 1'b1);

	// High-cycle count of each load while the window is open
	always @(posedge ref_clk_i) begin
		for (int i = 0; i < 3; i++) begin
			if (!meas_i)
				high_cnt_o[i] <= 8'h00;
			else if (pins_i[i] === 1'b1)
				high_cnt_o[i] <= high_cnt_o[i] + 8'h01;
		end
	end
endmodule : tcpo_pin_load

// file: verification/testbench.sv
// Self-checking bench for the timer compare and PWM output block.
// Assumes the package register map and a pulled-up shared pin D.
`timescale 1ns/1ps
module testbench;
	typedef struct packed {
		logic [2:0] sel;
		logic dir;
		logic dat;
		logic ext;
		logic oe;
		logic lvl;
	} tcpo_row_s;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic ext_en = 1'b0;
	logic ext_lvl = 1'b0;
	logic meas = 1'b0;
	logic [15:0] rdata;
	logic irq, pa, pb, pc, pd_o, pd_oe, tin_d, pd_lvl;
	logic [2:0] oe;
	logic [2:0][7:0] hcnt;
	int error_cnt = 0;
	int checked = 0;
	int n;
	// Pin D select, dir, port data, outside level, expected enable and wire
	tcpo_row_s rows [9] = '{8'b000_01000, 8'b000_11011, 8'b000_10010,
		8'b001_00011, 8'b010_00011, 8'b011_10011, 8'b100_00101,
		8'b111_10010, 8'b110_00000};
	logic [19:0] rst_tab [7] = '{{tcpo_pkg::ADDR_CTRL, 16'h0000},
		{tcpo_pkg::ADDR_IO_AB, 16'h0000}, {tcpo_pkg::ADDR_STATUS, 16'h0000},
		{tcpo_pkg::ADDR_GR_A, 16'hffff}, {tcpo_pkg::ADDR_GR_D, 16'hffff},
		{tcpo_pkg::ADDR_COUNT, 16'h0000}, {4'hf, 16'h0000}};

	always #12.5 ref_clk_i = ~ref_clk_i;

	tcpo_top #(.CNT_W(16)) u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_rdata_o(rdata), .irq_o(irq),
		.timer_pin_a_o(pa), .timer_pin_b_o(pb), .timer_pin_c_o(pc),
		.timer_pin_oe_o(oe), .pin_d_i(pd_lvl), .pin_d_o(pd_o),
		.pin_d_oe_o(pd_oe), .timer_in_d_o(tin_d));

	tcpo_pin_load u_load (.ref_clk_i(ref_clk_i), .meas_i(meas),
		.pins_i({pd_lvl, pc, pb}), .pin_d_o_i(pd_o), .pin_d_oe_i(pd_oe),
		.ext_en_i(ext_en), .ext_lvl_i(ext_lvl), .pin_d_lvl_o(pd_lvl),
		.high_cnt_o(hcnt));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk_i);
	endtask : cyc

	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk_i);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
		@(posedge ref_clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk_i);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask : rd_chk

	// Length of one whole level of pin A, skipping the partial one
	task automatic run_len(output int len);
		logic v;
		#1 v = pa;
		len = 0;
		for (int k = 0; k < 2; k++) begin
			len = 0;
			while (pa === v && len < 100) begin
				@(posedge ref_clk_i);
				#1 len++;
			end
			v = pa;
		end
	endtask : run_len

	task automatic end_sim();
		$display("Checks %0d, errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim

	initial begin
		cyc(5);
		rst_n_i <= 1'b1;
		wr_reg(tcpo_pkg::ADDR_CTRL, 16'h0020);
		foreach (rows[i]) begin
			ext_en <= !rows[i].oe;
			ext_lvl <= rows[i].ext;
			wr_reg(tcpo_pkg::ADDR_PORT_DIR, {11'h0, rows[i].dir, 4'h0});
			wr_reg(tcpo_pkg::ADDR_PORT_DATA, {11'h0, rows[i].dat, 4'h0});
			wr_reg(tcpo_pkg::ADDR_IO_CD, {9'h0, rows[i].sel, 4'h0});
			cyc(5);
			#1 chk(pd_oe, rows[i].oe);
			chk(pd_lvl, rows[i].lvl);
			if (!rows[i].oe)
				chk(tin_d, rows[i].ext);
		end
		ext_en <= 1'b0;
		wr_reg(tcpo_pkg::ADDR_GR_A, 16'h0004);
		wr_reg(tcpo_pkg::ADDR_IO_AB, 16'h0003);
		wr_reg(tcpo_pkg::ADDR_CTRL, 16'h0003);
		run_len(n);
		chk(n[15:0], 16'h0005);
		rd_chk(tcpo_pkg::ADDR_STATUS, 16'h0001);
		chk(irq, 1'b0);
		wr_reg(tcpo_pkg::ADDR_IRQ_EN, 16'h0001);
		cyc(2);
		#1 chk(irq, 1'b1);
		wr_reg(tcpo_pkg::ADDR_CTRL, 16'h0000);
		wr_reg(tcpo_pkg::ADDR_STAT_CLR, 16'h000f);
		cyc(2);
		#1 chk(irq, 1'b0);
		// Compare outputs: A drives low, B drives high
		wr_reg(tcpo_pkg::ADDR_COUNT, 16'h0000);
		wr_reg(tcpo_pkg::ADDR_GR_A, 16'h0002);
		wr_reg(tcpo_pkg::ADDR_GR_B, 16'h0003);
		wr_reg(tcpo_pkg::ADDR_IO_AB, 16'h0021);
		wr_reg(tcpo_pkg::ADDR_CTRL, 16'h0005);
		#1 chk({pa, pb}, 2'b10);
		cyc(6);
		#1 chk({pa, pb}, 2'b01);
		chk(oe, 3'b011);
		// PWM with conflicting per-match selections left in place
		wr_reg(tcpo_pkg::ADDR_CTRL, 16'h0000);
		wr_reg(tcpo_pkg::ADDR_COUNT, 16'h0000);
		wr_reg(tcpo_pkg::ADDR_GR_A, 16'h0009);
		wr_reg(tcpo_pkg::ADDR_GR_C, 16'h0003);
		wr_reg(tcpo_pkg::ADDR_GR_D, 16'h0009);
		wr_reg(tcpo_pkg::ADDR_IO_AB, 16'h0010);
		wr_reg(tcpo_pkg::ADDR_IO_CD, 16'h0002);
		wr_reg(tcpo_pkg::ADDR_CTRL, 16'h072b);
		cyc(12);
		meas <= 1'b1;
		cyc(20);
		meas <= 1'b0;
		#1 chk(hcnt[0], 8'd8);
		chk(hcnt[1], 8'd12);
		chk(hcnt[2], 8'd20);
		chk({oe[2:1], pd_oe}, 3'b111);
		// Reset in mid-run
		@(posedge ref_clk_i);
		rst_n_i <= 1'b0;
		cyc(2);
		#1 chk({irq, pa, pb, pc, oe, pd_oe, pd_o}, 9'h000);
		@(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		foreach (rst_tab[i])
			rd_chk(rst_tab[i][19:16], rst_tab[i][15:0]);
		end_sim();
	end

	// Tests need under a thousand cycles; allow ample margin
	initial begin
		cyc(5000);
		error_cnt++;
		end_sim();
	end
endmodule : testbench
